// ==== rtl/cpf_pkg.sv ====
// Purpose: Constants for the configuration protection fuse bank
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Reset values are the unprogrammed fuse states
package cpf_pkg;

    // ------------------------------------------------------------
    // Register indices and bus widths
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  OFS_DBG_OPT     = 4'h0;
    localparam logic [3:0]  OFS_PROG_PROT   = 4'h1;
    localparam logic [3:0]  OFS_BOOT_PROT   = 4'h2;
    localparam logic [3:0]  OFS_GUARD_STAT  = 4'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          DBG_DIS_BIT     = 7;
    localparam int          INSTRUCTION_EXTENSION_ENABLE_BIT       = 6;
    localparam int          SSP_BIT         = 2;
    localparam int          STK_BIT         = 0;
    localparam int          EEP_BIT         = 7;
    localparam int          BOOT_BIT        = 6;

    // ------------------------------------------------------------
    // Implemented masks and unprogrammed values
    // ------------------------------------------------------------
    localparam logic [7:0]  DBG_MASK        = 8'hC5;
    localparam logic [7:0]  DBG_RESET       = 8'h85;
    localparam logic [7:0]  PROG_MASK_SMALL = 8'h03;
    localparam logic [7:0]  PROG_MASK_LARGE = 8'h0F;
    localparam logic [7:0]  BOOT_MASK       = 8'hC0;
    localparam logic [7:0]  BOOT_RESET      = 8'hC0;

    typedef enum logic [1:0] {
        CPF_SEL_DBG,
        CPF_SEL_PROG,
        CPF_SEL_BOOT,
        CPF_SEL_NONE
    } cpf_sel_t;

    // Clear-only update: a one may drop to zero, never rise
    function automatic logic [7:0] cpf_clear_only(
        input logic [7:0] cur,
        input logic [7:0] wr,
        input logic [7:0] mask
    );
        cpf_clear_only = cur & (wr | ~mask) & mask;
    endfunction : cpf_clear_only

endpackage : cpf_pkg

// ==== rtl/cpf_bus_if.sv ====
// Purpose: Decoded write path between top and register slice
// Assumes: Same clock on both sides
// Notes:   One word-select plus data and strobe
`timescale 1ns/100ps
interface cpf_bus_if;
    import cpf_pkg::*;
    logic                wr_en;
    cpf_sel_t            sel;
    logic [DATA_W-1:0]   wdata;
    modport master (output wr_en, output sel, output wdata);
    modport slave  (input  wr_en, input  sel, input  wdata);
endinterface : cpf_bus_if

// ==== rtl/cpf_prot_word.sv ====
// Purpose: One clear-only protection word
// Assumes: Unprogrammed value is all implemented bits at one
// Notes:   Unimplemented bits are held at zero
`timescale 1ns/100ps
module cpf_prot_word #(
    parameter cpf_pkg::cpf_sel_t MY_SEL = cpf_pkg::CPF_SEL_PROG,
    parameter logic [7:0]        MASK   = 8'h0F
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Write path
    cpf_bus_if.slave        bus,
    // Stored word
    output logic [7:0]      value
);
    import cpf_pkg::*;

    logic [7:0] word_r;
    logic [7:0] word_nxt;
    wire        hit = bus.wr_en && (bus.sel == MY_SEL);

    assign word_nxt = hit ? cpf_clear_only(word_r, bus.wdata, MASK)
                          : word_r;
    assign value    = word_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_r <= MASK;
        end else begin
            word_r <= word_nxt;
        end
    end
endmodule : cpf_prot_word

// ==== rtl/cpf_fuse_bank.sv ====
// Purpose: Configuration and code-protection fuse bank
// Assumes: Programmer writes over plain strobe port
// Notes:   Reset stands for the unprogrammed state
`timescale 1ns/100ps
module cpf_fuse_bank #(
    parameter bit LARGE_MEM = 1'b1
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Register port
    input  wire logic [cpf_pkg::ADDR_W-1:0]   addr,
    input  wire logic [cpf_pkg::DATA_W-1:0]   wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    output logic      [cpf_pkg::DATA_W-1:0]   rdata,
    // Core option outputs
    output logic                              debugger_enable,
    output logic                              debug_pins_claimed,
    output logic                              instruction_extension_enable,
    output logic                              single_supply_programming_enable,
    output logic                              stack_overflow_reset_enable,
    // Protection outputs, high means protected
    output logic                              block0_read_guard,
    output logic                              block1_read_guard,
    output logic                              block2_read_guard,
    output logic                              block3_read_guard,
    output logic                              eeprom_read_guard,
    output logic                              boot_block_read_guard
);
    import cpf_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    localparam logic [7:0] PROG_MASK =
        LARGE_MEM ? PROG_MASK_LARGE : PROG_MASK_SMALL;

    cpf_bus_if bus ();

    wire cpf_sel_t sel_w =
        (addr == OFS_DBG_OPT)   ? CPF_SEL_DBG  :
        (addr == OFS_PROG_PROT) ? CPF_SEL_PROG :
        (addr == OFS_BOOT_PROT) ? CPF_SEL_BOOT : CPF_SEL_NONE;

    assign bus.wr_en = wr;
    assign bus.sel   = sel_w;
    assign bus.wdata = wdata;

    // ------------------------------------------------------------
    // Option word, freely programmable
    // ------------------------------------------------------------
    logic [7:0] dbg_r;
    logic [7:0] dbg_nxt;
    logic [7:0] prog_w;
    logic [7:0] boot_w;

    assign dbg_nxt = (wr && sel_w == CPF_SEL_DBG) ? (wdata & DBG_MASK)
                                                  : dbg_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dbg_r <= DBG_RESET;
        end else begin
            dbg_r <= dbg_nxt;
        end
    end

    // ------------------------------------------------------------
    // Protection words
    // ------------------------------------------------------------
    cpf_prot_word #(.MY_SEL(CPF_SEL_PROG), .MASK(PROG_MASK)) u_prog (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (bus.slave),
        .value (prog_w)
    );

    cpf_prot_word #(.MY_SEL(CPF_SEL_BOOT), .MASK(BOOT_MASK)) u_boot (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (bus.slave),
        .value (boot_w)
    );

    // ------------------------------------------------------------
    // Read mux and outputs
    // ------------------------------------------------------------
    wire [7:0] guard_stat = {2'h0, ~boot_w[EEP_BIT], ~boot_w[BOOT_BIT],
                             ~prog_w[3:0] & PROG_MASK[3:0]};
    wire [7:0] rd_mux =
        (addr == OFS_DBG_OPT)    ? dbg_r  :
        (addr == OFS_PROG_PROT)  ? prog_w :
        (addr == OFS_BOOT_PROT)  ? boot_w :
        (addr == OFS_GUARD_STAT) ? guard_stat : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata                            <= 8'h00;
            debugger_enable                  <= 1'b0;
            debug_pins_claimed               <= 1'b0;
            instruction_extension_enable     <= 1'b0;
            single_supply_programming_enable <= 1'b1;
            stack_overflow_reset_enable      <= 1'b1;
            block0_read_guard                <= 1'b0;
            block1_read_guard                <= 1'b0;
            block2_read_guard                <= 1'b0;
            block3_read_guard                <= 1'b0;
            eeprom_read_guard                <= 1'b0;
            boot_block_read_guard            <= 1'b0;
        end else begin
            rdata <= rd ? rd_mux : 8'h00;
            debugger_enable    <= ~dbg_nxt[DBG_DIS_BIT];
            debug_pins_claimed <= ~dbg_nxt[DBG_DIS_BIT];
            instruction_extension_enable <= dbg_nxt[INSTRUCTION_EXTENSION_ENABLE_BIT];
            single_supply_programming_enable <= dbg_nxt[SSP_BIT];
            stack_overflow_reset_enable      <= dbg_nxt[STK_BIT];
            block0_read_guard     <= ~prog_w[0];
            block1_read_guard     <= ~prog_w[1];
            block2_read_guard     <= LARGE_MEM & ~prog_w[2];
            block3_read_guard     <= LARGE_MEM & ~prog_w[3];
            eeprom_read_guard     <= ~boot_w[EEP_BIT];
            boot_block_read_guard <= ~boot_w[BOOT_BIT];
        end
    end
endmodule : cpf_fuse_bank

// ==== verif/cpf_fuse_bank_assertions.sv ====
// Purpose: Port-level checks for the fuse bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Guards lag their register by one edge
`timescale 1ns/100ps
module cpf_fuse_bank_assertions #(
    parameter bit LARGE_MEM = 1'b1
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       debugger_enable,
    input wire logic       debug_pins_claimed,
    input wire logic       instruction_extension_enable,
    input wire logic       block0_read_guard,
    input wire logic       block3_read_guard,
    input wire logic       eeprom_read_guard,
    input wire logic       boot_block_read_guard
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pins_follow_dbg: assert property (
        debug_pins_claimed == debugger_enable) else $error("pins flag off");
    a_dbg_write: assert property (
        wr && addr == 4'h0 |=> debugger_enable == !$past(wdata[7]))
        else $error("debugger enable wrong");
    a_ext_write: assert property (
        wr && addr == 4'h0 |=> instruction_extension_enable == $past(wdata[6]))
        else $error("extension enable wrong");
    a_blk0_clear: assert property (
        wr && addr == 4'h1 && !wdata[0] |-> ##2 block0_read_guard)
        else $error("block 0 guard not set");
    a_blk3_clear: assert property (
        LARGE_MEM && wr && addr == 4'h1 && !wdata[3] |-> ##2 block3_read_guard)
        else $error("block 3 guard not set");
    a_eep_clear: assert property (
        wr && addr == 4'h2 && !wdata[7] |-> ##2 eeprom_read_guard)
        else $error("eeprom guard not set");
    a_boot_clear: assert property (
        wr && addr == 4'h2 && !wdata[6] |-> ##2 boot_block_read_guard)
        else $error("boot guard not set");
    a_guard_sticks: assert property (
        block0_read_guard |=> block0_read_guard) else $error("guard dropped");
    a_prog_top_zero: assert property (
        rd && addr == 4'h1 |=> rdata[7:4] == 4'h0) else $error("bits 7-4 set");
endmodule : cpf_fuse_bank_assertions
bind cpf_fuse_bank cpf_fuse_bank_assertions #(.LARGE_MEM(LARGE_MEM)) i_chk (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .debugger_enable,
    .debug_pins_claimed, .instruction_extension_enable, .block0_read_guard,
    .block3_read_guard, .eeprom_read_guard, .boot_block_read_guard);

// ==== verif/cpf_fuse_bank_tb_top.sv ====
// Purpose: Self-checking bench for the fuse bank
// Assumes: Registers on a one-cycle strobe port
// Notes:   Random writes against a shadow model
`timescale 1ns/100ps
module cpf_fuse_bank_tb_top;
    import cpf_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata, got, eo, go;
    logic       dbg, pins, ext, ssp, stk, g0, g1, g2, g3, ge, gb;
    logic [7:0] rdata_s;
    logic       g0s, g1s, g2s, g3s, ges, gbs;
    logic [7:0] m [3] = '{DBG_RESET, PROG_MASK_LARGE, BOOT_RESET};
    logic [7:0] k [3] = '{DBG_MASK, PROG_MASK_LARGE, BOOT_MASK};
    logic [31:0] r;
    integer     seed = 32'ha2c3;
    int         bad_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    always #5 clk = ~clk;
    cpf_fuse_bank #(.LARGE_MEM(1'b1)) i_cpf_fuse_bank (.clk, .rst_n, .addr,
        .wdata, .wr, .rd, .rdata, .debugger_enable(dbg),
        .debug_pins_claimed(pins), .instruction_extension_enable(ext),
        .single_supply_programming_enable(ssp),
        .stack_overflow_reset_enable(stk), .block0_read_guard(g0),
        .block1_read_guard(g1), .block2_read_guard(g2),
        .block3_read_guard(g3), .eeprom_read_guard(ge),
        .boot_block_read_guard(gb));
    // Small-memory variant on the same port traffic
    cpf_fuse_bank #(.LARGE_MEM(1'b0)) i_cpf_fuse_bank_small (.clk, .rst_n,
        .addr, .wdata, .wr, .rd, .rdata(rdata_s), .debugger_enable(),
        .debug_pins_claimed(), .instruction_extension_enable(),
        .single_supply_programming_enable(),
        .stack_overflow_reset_enable(), .block0_read_guard(g0s),
        .block1_read_guard(g1s), .block2_read_guard(g2s),
        .block3_read_guard(g3s), .eeprom_read_guard(ges),
        .boot_block_read_guard(gbs));
    function automatic logic [7:0] stat();
        return {2'b00, ~m[2][7:6], ~m[1][3:0]};
    endfunction : stat
    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        return a < 4'h3 ? m[a[1:0]] : (a == 4'h3 ? stat() : 8'h00);
    endfunction : exp_rd
    function automatic logic [7:0] exp_rd_s(input logic [3:0] a);
        if (a == 4'h1) return m[1] & PROG_MASK_SMALL;
        if (a == 4'h3) return stat() & {4'hF, PROG_MASK_SMALL[3:0]};
        return exp_rd(a);
    endfunction : exp_rd_s
    task automatic close_out();
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, s, input logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= s;
        addr <= a;
        wdata <= d;
    endtask : bus
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        if (a == 4'h0) m[0] = d & k[0];
        else if (a < 4'h3) m[a[1:0]] = m[a[1:0]] & d & k[a[1:0]];
    endtask : put
    task automatic get(input logic [3:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        #1 got = rdata;
        chk("read", exp_rd(a), got);
        chk("read small", exp_rd_s(a), rdata_s);
    endtask : get
    task automatic chk_outs();
        repeat (2) @(posedge clk);
        #1 eo = {3'b000, ~m[0][7], ~m[0][7], m[0][6], m[0][2], m[0][0]};
        go = {3'b000, dbg, pins, ext, ssp, stk};
        chk("options", eo, go);
        chk("guards", stat(), {2'b00, ge, gb, g3, g2, g1, g0});
        chk("small guards", exp_rd_s(4'h3),
            {2'b00, ges, gbs, g3s, g2s, g1s, g0s});
    endtask : chk_outs
    task automatic from_reset();
        m = '{DBG_RESET, PROG_MASK_LARGE, BOOT_RESET};
        for (int i = 0; i < 6; i++) get(4'(i));
        chk_outs();
    endtask : from_reset
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        from_reset();
        put(4'h1, 8'hFE);
        put(4'h1, 8'hFF);
        put(4'h3, 8'h00);
        get(4'h1);
        put(4'h2, 8'h7F);
        get(4'h3);
        put(4'h0, 8'h40);
        get(4'h0);
        chk_outs();
        repeat (60) begin
            r = $random(seed);
            put({1'b0, r[2:0]}, r[15:8] | r[23:16]);
            get({1'b0, r[26:24]});
            chk_outs();
        end
        put(4'h1, 8'hF7);
        put(4'h2, 8'hBF);
        get(4'h3);
        chk_outs();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        from_reset();
        close_out();
    end
endmodule : cpf_fuse_bank_tb_top
